// ---- rtl/fault_latch_pkg.sv ----
// constants for the laser fault classification and latching block
// assumes a 40 MHz core clock; no bus, all control and status are ports
package fault_latch_pkg;
  // clock rate and output response bound
  localparam int CLK_HZ = 40000000;
  localparam int FAULT_RESP_US = 1;
  localparam int FAULT_RESP_CYC = (FAULT_RESP_US * (CLK_HZ / 1000000) > 0) ?
                                  FAULT_RESP_US * (CLK_HZ / 1000000) : 1;
  // fault input vector field positions
  localparam int LATCH_TEMP_BIT = 0;
  localparam int LATCH_SHUTTER_BIT = 1;
  localparam int LATCH_WIDTH = 2;
  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;
  // reset values
  localparam logic RST_LOW = 1'h0;
  localparam logic RST_HIGH = 1'h1;
endpackage : fault_latch_pkg

// ---- rtl/fault_sync_if.sv ----
// carrier between the top module and its pin synchroniser
// assumes one clock domain driven by clk_i
`timescale 1ns/1ps
interface fault_sync_if #(parameter int WIDTH = 6);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;
  modport sync_side (input raw, output synced);
  modport user_side (output raw, input synced);
endinterface : fault_sync_if

// ---- rtl/laser_fault_latch_control.sv ----
// fault classification and latching control for an rf-excited laser
// assumes fault sense inputs and enable arrive asynchronously from pins
// fault classes handled here:
//   disruptive (reflected power, duty limit): flagged and throttled, run goes on
//   latching (temperature, shutter): emission stops, lines and summary latch
//   terminal (power-up check): summary only, left only through resetn_i
// every pin passes two flops, so a status line moves three edges after
// its cause; at 25 ns per edge that is far inside the microsecond budget
// limitation: a cause shorter than one clock period may be missed entirely
// trade-off: the retiming costs two edges of response but removes any
// metastable level from the state machine and the latch flags
`timescale 1ns/1ps
module laser_fault_latch_control (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // enable / fault reset pin, low when tied to return
  input wire logic enable_n_i,
  // power-up terminal check status
  input wire logic selftest_done_i,
  input wire logic terminal_fault_i,
  // latching fault sense levels
  input wire logic over_temp_i,
  input wire logic shutter_fault_i,
  // disruptive fault sense levels
  input wire logic reflected_high_i,
  input wire logic duty_limit_i,
  // emission control and status
  output logic emit_allow_o,
  output logic throttle_o,
  output logic system_fault_o,
  output logic temp_fault_o,
  output logic shutter_fault_o,
  output logic reflected_fault_o,
  output logic duty_fault_o
);
  typedef enum logic [2:0] {
    ST_SELFTEST, ST_WAIT_RELEASE, ST_IDLE, ST_RUN, ST_FAULT, ST_TERMINAL
  } ctrl_state_type;

  ctrl_state_type state_reg;
  ctrl_state_type state_next;
  logic en_seen_off_reg;
  logic [fault_latch_pkg::LATCH_WIDTH-1:0] latched_reg;
  logic [fault_latch_pkg::LATCH_WIDTH-1:0] latched_next;
  logic [fault_latch_pkg::LATCH_WIDTH-1:0] latch_now;
  logic enable_act;
  logic enable_prev_reg;
  logic enable_rise;
  logic cause_clear;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  // every level is retimed here; nothing below reads a raw pin
  fault_sync_if #(.WIDTH(7)) sync_bus ();

  assign sync_bus.raw = {duty_limit_i, reflected_high_i, shutter_fault_i, over_temp_i,
                         terminal_fault_i, selftest_done_i, ~enable_n_i};

  pin_sync u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .bus(sync_bus.sync_side)
  );

  logic s_enable;
  logic s_done;
  logic s_term;
  logic s_temp;
  logic s_shut;
  logic s_refl;
  logic s_duty;
  assign {s_duty, s_refl, s_shut, s_temp, s_term, s_done, s_enable} = sync_bus.synced;

  assign enable_act = s_enable;
  assign latch_now[fault_latch_pkg::LATCH_TEMP_BIT] = s_temp;
  assign latch_now[fault_latch_pkg::LATCH_SHUTTER_BIT] = s_shut;
  assign cause_clear = (latch_now == '0);

  //////////////////////////////////////////////////////////////////////////
  // enable edge tracking: a rise only counts after a release was seen
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enable_prev_reg <= fault_latch_pkg::RST_LOW;
    end else begin
      enable_prev_reg <= enable_act;
    end
  end

  assign enable_rise = enable_act & ~enable_prev_reg;

  // enable held from power-up is not trusted until released once; the
  // synchroniser's reset zeros are no release, so only look after self-test
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_seen_off_reg <= fault_latch_pkg::RST_LOW;
    end else if (state_reg != ST_SELFTEST && !enable_act) begin
      en_seen_off_reg <= fault_latch_pkg::RST_HIGH;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // latched fault flags: set wins over the clearing toggle
  // the lines read the next value so they drop on the restart edge itself
  always_comb begin
    if (state_reg == ST_FAULT && enable_rise && cause_clear) begin
      latched_next = latch_now;
    end else begin
      latched_next = latched_reg | latch_now;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latched_reg <= '0;
    end else begin
      latched_reg <= latched_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_SELFTEST: begin
        if (s_done && s_term) begin
          state_next = ST_TERMINAL;
        end else if (s_done) begin
          state_next = ST_WAIT_RELEASE;
        end
      end
      ST_WAIT_RELEASE: begin
        // a pin held low since power-up must be released before a run
        if (en_seen_off_reg || !enable_act) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // a flag caught before the first run still forces the fault state
        if ((latch_now | latched_reg) != '0) begin
          state_next = ST_FAULT;
        end else if (enable_rise) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        // dropping enable is an orderly stop, not a fault
        if (latch_now != '0) begin
          state_next = ST_FAULT;
        end else if (!enable_act) begin
          state_next = ST_IDLE;
        end
      end
      ST_FAULT: begin
        // only a fresh rise with the cause gone restarts emission
        if (enable_rise && cause_clear) begin
          state_next = ST_RUN;
        end
      end
      // only resetn_i leaves; the check result is not read again
      ST_TERMINAL: state_next = ST_TERMINAL;
      default: state_next = ST_SELFTEST;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ST_SELFTEST;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status outputs, all registered; a fault appears one edge after sync
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      emit_allow_o <= fault_latch_pkg::RST_LOW;
      system_fault_o <= fault_latch_pkg::RST_LOW;
      temp_fault_o <= fault_latch_pkg::RST_LOW;
      shutter_fault_o <= fault_latch_pkg::RST_LOW;
    end else begin
      emit_allow_o <= (state_next == ST_RUN);
      // active high, a few cycles from the cause, well inside a microsecond
      system_fault_o <= (state_next == ST_FAULT) || (state_next == ST_TERMINAL);
      // next value, so a cleared line falls on the edge emission restarts
      temp_fault_o <= latched_next[fault_latch_pkg::LATCH_TEMP_BIT];
      shutter_fault_o <= latched_next[fault_latch_pkg::LATCH_SHUTTER_BIT];
    end
  end

  // disruptive faults throttle the drive but never stop the state machine
  // outside a run there is nothing to throttle, so only the lines report it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      throttle_o <= fault_latch_pkg::RST_LOW;
      reflected_fault_o <= fault_latch_pkg::RST_LOW;
      duty_fault_o <= fault_latch_pkg::RST_LOW;
    end else begin
      throttle_o <= (s_refl | s_duty) & (state_next == ST_RUN);
      reflected_fault_o <= s_refl;
      duty_fault_o <= s_duty;
    end
  end
endmodule : laser_fault_latch_control

// ---- rtl/pin_sync.sv ----
// two-flop synchroniser for a vector of asynchronous pin levels
// assumes each bit is an independent level, not a multi-bit word
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // carrier
  fault_sync_if.sync_side bus
);
  logic [$bits(bus.raw)-1:0] meta_reg;
  logic [$bits(bus.raw)-1:0] sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= bus.raw;
      sync_reg <= meta_reg;
    end
  end

  assign bus.synced = sync_reg;
endmodule : pin_sync

// ---- verif/fault_latch_properties.sv ----
// checker: timing of the laser fault status lines
// assumes outputs lag a pin change by three clock edges
`timescale 1ns/1ps
module fault_latch_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // pins
  input wire logic enable_n_i,
  input wire logic selftest_done_i,
  input wire logic terminal_fault_i,
  input wire logic over_temp_i,
  input wire logic shutter_fault_i,
  input wire logic reflected_high_i,
  input wire logic duty_limit_i,
  // status
  input wire logic emit_allow_o,
  input wire logic throttle_o,
  input wire logic system_fault_o,
  input wire logic temp_fault_o,
  input wire logic shutter_fault_o,
  input wire logic reflected_fault_o,
  input wire logic duty_fault_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // shut down with summary raised
  sequence s_shut; !emit_allow_o && system_fault_o; endsequence
  property p_latched_off; temp_fault_o || shutter_fault_o |-> s_shut; endproperty
  property p_latch_resp; emit_allow_o && $rose(over_temp_i) |-> ##3 s_shut ##0 temp_fault_o;
  endproperty
  // a present cause must block any clearing toggle
  property p_stay; system_fault_o && ($past(over_temp_i, 2) || $past(shutter_fault_i, 2))
    |=> system_fault_o && !emit_allow_o; endproperty
  property p_refl; $past(reflected_high_i, 2) |=> reflected_fault_o; endproperty
  property p_duty; duty_limit_i |-> ##3 duty_fault_o; endproperty
  // disruptive causes never stop a run
  property p_keep_run; emit_allow_o && !$past(over_temp_i, 2) && !$past(shutter_fault_i, 2)
    && !$past(enable_n_i, 2) |=> emit_allow_o; endproperty
  property p_term; $past(terminal_fault_i, 2) && $past(selftest_done_i, 2) |=> s_shut;
  endproperty
  // emission starts only on a fresh high-to-low enable edge
  property p_fresh_en; $rose(emit_allow_o) |-> !$past(enable_n_i, 3) && $past(enable_n_i, 4);
  endproperty
  a_latched_off: assert property (p_latched_off) else $error("latched on");
  a_latch_resp: assert property (p_latch_resp) else $error("slow latch");
  a_stay: assert property (p_stay) else $error("early clear");
  a_refl: assert property (p_refl) else $error("refl line");
  a_duty: assert property (p_duty) else $error("duty line");
  a_keep_run: assert property (p_keep_run) else $error("run lost");
  a_term: assert property (p_term) else $error("terminal");
  a_fresh_en: assert property (p_fresh_en) else $error("stale enable");
endmodule : fault_latch_properties

// ---- verif/host_ctrl_model.sv ----
// host controller model driving the enable/fault-reset pin
// assumes the pin reads high while left open
`timescale 1ns/1ps
module host_ctrl_model (
  // clock
  input wire logic clk_i,
  // enable pin, low when tied to return
  output logic enable_n_o
);
  initial enable_n_o = 1'h1; // open until the supply is up
  // open for n edges then reconnect; doubles as the fault reset
  task automatic pulse_enable(input int n);
    @(posedge clk_i) enable_n_o <= 1'h1;
    repeat (n) @(posedge clk_i);
    enable_n_o <= 1'h0;
  endtask : pulse_enable
endmodule : host_ctrl_model

// ---- verif/tb_top.sv ----
// bench: power-up, disruptive, latching and terminal sequences
// assumes host_ctrl_model owns the enable pin
`timescale 1ns/1ps
module tb_top;
  logic clk_i, resetn_i, enable_n_i, selftest_done_i, terminal_fault_i, over_temp_i;
  logic shutter_fault_i, reflected_high_i, duty_limit_i, emit_allow_o, throttle_o;
  logic system_fault_o, temp_fault_o, shutter_fault_o, reflected_fault_o, duty_fault_o;
  int n_fail = 0;
  int comparisons = 0;
  `define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
    $display("BAD %0t %h %h", $time, a, e); end end
  laser_fault_latch_control dut_u (.clk_i, .resetn_i, .enable_n_i, .selftest_done_i,
    .terminal_fault_i, .over_temp_i, .shutter_fault_i, .reflected_high_i, .duty_limit_i,
    .emit_allow_o, .throttle_o, .system_fault_o, .temp_fault_o, .shutter_fault_o,
    .reflected_fault_o, .duty_fault_o);
  host_ctrl_model host (.clk_i, .enable_n_o(enable_n_i));
  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step
  // reset with the pin already tied to return
  task automatic power_up(input logic t);
    resetn_i <= 1'h0;
    selftest_done_i <= 1'h0;
    terminal_fault_i <= t;
    host.pulse_enable(1);
    step(4);
    resetn_i <= 1'h1;
    selftest_done_i <= 1'h1;
    step(8);
  endtask : power_up
  task automatic complete_run;
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////
  // main sequence; all waits are fixed by the three-edge latency
  initial begin
    {over_temp_i, shutter_fault_i, reflected_high_i, duty_limit_i} <= 4'h0;
    power_up(1'h0);
    `CHK(emit_allow_o, 1'h0)
    host.pulse_enable(2);
    step(4);
    `CHK(emit_allow_o, 1'h1)
    {reflected_high_i, duty_limit_i} <= 2'h3;
    step(4);
    `CHK({emit_allow_o, throttle_o, system_fault_o, reflected_fault_o, duty_fault_o}, 5'h1b)
    {reflected_high_i, duty_limit_i} <= 2'h0;
    step(4);
    `CHK({emit_allow_o, throttle_o, reflected_fault_o, duty_fault_o}, 4'h8)
    for (int i = 0; i < 2; i++) begin
      over_temp_i <= (i == 0);
      shutter_fault_i <= (i == 1);
      step(4);
      `CHK({emit_allow_o, system_fault_o, temp_fault_o, shutter_fault_o}, {2'h1, i == 0, i == 1})
      host.pulse_enable(2);
      step(4);
      `CHK(emit_allow_o, 1'h0)
      {over_temp_i, shutter_fault_i} <= 2'h0;
      step(4);
      `CHK(system_fault_o, 1'h1)
      host.pulse_enable(2);
      step(4);
      `CHK({emit_allow_o, system_fault_o, temp_fault_o, shutter_fault_o}, 4'h8)
    end
    power_up(1'h1);
    host.pulse_enable(2);
    step(4);
    `CHK({emit_allow_o, system_fault_o}, 2'h1)
    complete_run();
  end
endmodule : tb_top
bind laser_fault_latch_control fault_latch_properties chk_u (.clk_i, .resetn_i, .enable_n_i,
  .selftest_done_i, .terminal_fault_i, .over_temp_i, .shutter_fault_i, .reflected_high_i,
  .duty_limit_i, .emit_allow_o, .throttle_o, .system_fault_o, .temp_fault_o,
  .shutter_fault_o, .reflected_fault_o, .duty_fault_o);
